/* logic/sas_pkg.sv */
// Constants shared by the converter sequencer and its bit-trial engine.
// Assumes a plain register port with byte-wide data and read data one cycle after the strobe.
package sas_pkg;
	localparam int          RES_BITS      = 10;
	localparam int          CHAN_BITS     = 4;
	// Register offsets
	localparam logic [3:0]  OFS_CTRL0     = 4'h0;
	localparam logic [3:0]  OFS_CTRL1     = 4'h1;
	localparam logic [3:0]  OFS_RES_HI    = 4'h2;
	localparam logic [3:0]  OFS_RES_LO    = 4'h3;
	localparam logic [3:0]  OFS_IRQ_STAT  = 4'h4;
	localparam logic [3:0]  OFS_IRQ_MASK  = 4'h5;
	// Control 0 fields
	localparam int          C0_ON         = 0;
	localparam int          C0_GO         = 1;
	localparam int          C0_CHAN_LO    = 2;
	// Control 1 fields
	localparam int          C1_VREF       = 0;
	localparam int          C1_CLK_LO     = 4;
	localparam int          CLK_SEL_BITS  = 3;
	// Status and mask fields
	localparam int          IRQ_DONE      = 0;
	// Reset values
	localparam logic [7:0]  CTRL0_RST     = 8'h00;
	localparam logic [7:0]  CTRL1_RST     = 8'h00;
	localparam logic [7:0]  MASK_RST      = 8'h00;
	// Conversion clock divider: bit period is 2 to the power (select + 1) system cycles
	localparam int          DIV_BITS      = 9;
	// Engine states
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_TRIAL, ST_FINISH} sas_state_t;
endpackage

/* logic/sas_sar_engine.sv */
// Successive-approximation bit-trial engine: one trial per conversion clock tick.
// Assumes the comparator answer is valid in the tick after the trial code is driven.
`timescale 1ns/10ps
module sas_sar_engine
	import sas_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// Control
	input  wire logic                start,
	input  wire logic                tick,
	input  wire logic                comp_high,
	// Results
	output logic [RES_BITS-1:0]      trial,
	output logic                     hold,
	output logic                     done,
	output logic [RES_BITS-1:0]      result
);
	typedef struct packed {
		sas_state_t              st;
		logic [RES_BITS-1:0]     code;
		logic [RES_BITS-1:0]     mask;
		logic                    done;
	} sas_eng_t;

	sas_eng_t s_r;
	sas_eng_t s_nxt;

	// Next state: sample for one tick, then one trial per tick from the top bit down
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			ST_IDLE: begin
				if (start) begin
					s_nxt.st = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (tick) begin
					s_nxt.st = ST_TRIAL;
					s_nxt.mask = {1'b1, {(RES_BITS-1){1'b0}}};
					s_nxt.code = {1'b1, {(RES_BITS-1){1'b0}}};
				end
			end
			ST_TRIAL: begin
				if (tick) begin
					// Keep the trial bit only when the input is at or above the trial level
					s_nxt.code = comp_high ? s_r.code : (s_r.code & ~s_r.mask);
					s_nxt.mask = s_r.mask >> 1;
					if (s_r.mask[0]) begin
						s_nxt.st = ST_FINISH;
					end else begin
						s_nxt.code = (comp_high ? s_r.code : (s_r.code & ~s_r.mask)) | (s_r.mask >> 1);
					end
				end
			end
			ST_FINISH: begin
				s_nxt.done = 1'b1;
				s_nxt.st = ST_IDLE;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign trial  = s_r.code;
	assign hold   = (s_r.st == ST_TRIAL);
	assign done   = s_r.done;
	assign result = s_r.code;
endmodule

/* logic/sas_top.sv */
// Converter sequencer: registers, conversion clock divider, start/done, result pair and interrupt.
// Assumes one clock, synchronous inputs, and an analog front end answering comparator trials.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
module sas_top
	import sas_pkg::*;
(
	// Clock and reset
	input  wire logic                  SYS_CLK,
	input  wire logic                  RESET,
	// Register port
	input  wire logic [3:0]            ADDR,
	input  wire logic [7:0]            WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic [7:0]                 RDATA,
	// Analog front end
	output logic [CHAN_BITS-1:0]       CHAN_SEL,
	output logic                       VREF_EXT,
	output logic                       CONV_ON,
	output logic                       SAMPLE_HOLD,
	output logic [RES_BITS-1:0]        TRIAL_CODE,
	input  wire logic                  COMP_HIGH,
	// System
	output logic                       IRQ,
	output logic                       WAKE
);
	typedef struct packed {
		logic [7:0]              ctrl0;
		logic [7:0]              ctrl1;
		logic [RES_BITS-1:0]     res;
		logic                    stat;
		logic                    mask;
		logic [7:0]              rdata;
		logic [DIV_BITS-1:0]     div;
		logic                    tick;
		logic                    irq;
		logic                    wake;
		logic [CHAN_BITS-1:0]    chan;
		logic                    vref;
		logic                    on;
		logic                    hold;
		logic [RES_BITS-1:0]     trial;
	} sas_top_t;

	sas_top_t s_r;
	sas_top_t s_nxt;

	logic                  eng_start;
	logic                  eng_reset;
	logic                  eng_done;
	logic                  eng_hold;
	logic [RES_BITS-1:0]   eng_trial;
	logic [RES_BITS-1:0]   eng_result;
	logic                  wr_go;
	logic [DIV_BITS-1:0]   div_lim;

	// Go accepted only from a write that also sets the on bit, and only while idle
	assign wr_go = WR && (ADDR == OFS_CTRL0) && WDATA[C0_GO] && WDATA[C0_ON] && !s_r.ctrl0[C0_GO];
	assign eng_start = wr_go;
	// Switching off holds the engine in reset, so an abandoned conversion can never resume later
	assign eng_reset = RESET || !s_nxt.ctrl0[C0_ON];
	// Divider limit from the clock select field; wider selects give slower bit trials
	assign div_lim = DIV_BITS'((2 << s_r.ctrl1[C1_CLK_LO +: CLK_SEL_BITS]) - 1);

	sas_sar_engine u_eng (
		.clk       (SYS_CLK),
		.reset     (eng_reset),
		.start     (eng_start),
		.tick      (s_r.tick),
		.comp_high (COMP_HIGH),
		.trial     (eng_trial),
		.hold      (eng_hold),
		.done      (eng_done),
		.result    (eng_result)
	);

	// Register writes, conversion completion, interrupt and read mux
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		// Divider free-runs only while converting, so each conversion starts on a full period
		if (s_r.ctrl0[C0_GO] && !s_r.tick && (s_r.div >= div_lim)) begin
			s_nxt.div = '0;
			s_nxt.tick = 1'b1;
		end else if (s_r.ctrl0[C0_GO]) begin
			s_nxt.div = s_r.div + 1'b1;
		end else begin
			s_nxt.div = '0;
		end
		if (WR) begin
			case (ADDR)
				OFS_CTRL0: begin
					s_nxt.ctrl0 = WDATA;
					// Go cannot be cleared mid-conversion by writing it zero, nor set while off
					s_nxt.ctrl0[C0_GO] = s_r.ctrl0[C0_GO] | wr_go;
				end
				OFS_CTRL1: begin
					s_nxt.ctrl1 = WDATA;
				end
				OFS_IRQ_STAT: begin
					if (WDATA[IRQ_DONE]) begin
						s_nxt.stat = 1'b0;
					end
				end
				OFS_IRQ_MASK: begin
					s_nxt.mask = WDATA[IRQ_DONE];
				end
				default: begin
				end
			endcase
		end
		// Completion: result, flag and go bit all change together; set beats a same-cycle clear
		if (eng_done) begin
			s_nxt.res = eng_result;
			s_nxt.stat = 1'b1;
			s_nxt.ctrl0[C0_GO] = 1'b0;
		end
		// Turning the module off abandons any conversion: go drops and the engine is reset
		if (!s_nxt.ctrl0[C0_ON]) begin
			s_nxt.ctrl0[C0_GO] = 1'b0;
		end
		s_nxt.irq = s_nxt.stat & s_nxt.mask;
		// Wake needs no global enable; it follows the masked flag alone
		s_nxt.wake = s_nxt.stat & s_nxt.mask;
		s_nxt.chan = s_nxt.ctrl0[C0_CHAN_LO +: CHAN_BITS];
		s_nxt.vref = s_nxt.ctrl1[C1_VREF];
		s_nxt.on = s_nxt.ctrl0[C0_ON];
		s_nxt.hold = eng_hold;
		s_nxt.trial = eng_trial;
		s_nxt.rdata = 8'h00;
		if (RD) begin
			case (ADDR)
				OFS_CTRL0: s_nxt.rdata = s_r.ctrl0;
				OFS_CTRL1: s_nxt.rdata = s_r.ctrl1;
				OFS_RES_HI: s_nxt.rdata = {6'h00, s_r.res[RES_BITS-1:8]};
				OFS_RES_LO: s_nxt.rdata = s_r.res[7:0];
				OFS_IRQ_STAT: s_nxt.rdata = {7'h00, s_r.stat};
				OFS_IRQ_MASK: s_nxt.rdata = {7'h00, s_r.mask};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			s_r <= '0;
			s_r.ctrl0 <= CTRL0_RST;
			s_r.ctrl1 <= CTRL1_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RDATA       = s_r.rdata;
	assign CHAN_SEL    = s_r.chan;
	assign VREF_EXT    = s_r.vref;
	assign CONV_ON     = s_r.on;
	assign SAMPLE_HOLD = s_r.hold;
	assign TRIAL_CODE  = s_r.trial;
	assign IRQ         = s_r.irq;
	assign WAKE        = s_r.wake;

	// Go set by a valid write reads back as one the next cycle
	property p_go_set;
		@(posedge SYS_CLK) disable iff (RESET) wr_go |=> s_r.ctrl0[C0_GO];
	endproperty
	a_go_set: assert property (p_go_set) else $error("go bit not set after start");

	// Done sets flag and clears go at once
	property p_done_flag;
		@(posedge SYS_CLK) disable iff (RESET) eng_done |=> (s_r.stat && !s_r.ctrl0[C0_GO]);
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("flag or go wrong after done");

	// Go stays high until completion or power-off
	property p_go_hold;
		@(posedge SYS_CLK) disable iff (RESET)
			(s_r.ctrl0[C0_GO] && !eng_done && s_nxt.ctrl0[C0_ON]) |=> s_r.ctrl0[C0_GO];
	endproperty
	a_go_hold: assert property (p_go_hold) else $error("go dropped early");

	// Result captured on done
	property p_result;
		@(posedge SYS_CLK) disable iff (RESET) eng_done |=> (s_r.res == $past(eng_result));
	endproperty
	a_result: assert property (p_result) else $error("result not loaded");

	// Flag only falls by a software clear write
	property p_flag_sticky;
		@(posedge SYS_CLK) disable iff (RESET)
			(s_r.stat && !(WR && ADDR == OFS_IRQ_STAT && WDATA[IRQ_DONE])) |=> s_r.stat;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	// Interrupt equals the masked flag, both registered together
	property p_irq;
		@(posedge SYS_CLK) disable iff (RESET) IRQ == (s_r.stat && s_r.mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing");

	// Wake tracks the interrupt, independent of any global enable
	property p_wake;
		@(posedge SYS_CLK) disable iff (RESET) WAKE == IRQ;
	endproperty
	a_wake: assert property (p_wake) else $error("wake differs from irq");

	// High result read shows the upper two bits with zeros above
	property p_res_hi;
		@(posedge SYS_CLK) disable iff (RESET)
			(RD && ADDR == OFS_RES_HI && !eng_done) |=> (RDATA == {6'h00, $past(s_r.res[9:8])});
	endproperty
	a_res_hi: assert property (p_res_hi) else $error("high result read wrong");

	// Channel output follows the select field
	property p_chan;
		@(posedge SYS_CLK) disable iff (RESET) CHAN_SEL == s_r.ctrl0[C0_CHAN_LO +: CHAN_BITS];
	endproperty
	a_chan: assert property (p_chan) else $error("channel output wrong");

	// Reference output follows its bit
	property p_vref;
		@(posedge SYS_CLK) disable iff (RESET) VREF_EXT == s_r.ctrl1[C1_VREF];
	endproperty
	a_vref: assert property (p_vref) else $error("reference output wrong");

	// Control 1 takes the written byte whole
	property p_ctrl1_wr;
		@(posedge SYS_CLK) disable iff (RESET) (WR && ADDR == OFS_CTRL1) |=> (s_r.ctrl1 == $past(WDATA));
	endproperty
	a_ctrl1_wr: assert property (p_ctrl1_wr) else $error("control 1 write lost");

	// Mask bit takes the written value
	property p_mask_wr;
		@(posedge SYS_CLK) disable iff (RESET) (WR && ADDR == OFS_IRQ_MASK) |=> (s_r.mask == $past(WDATA[IRQ_DONE]));
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

	// A one written to the flag clears it when no completion competes
	property p_flag_clear;
		@(posedge SYS_CLK) disable iff (RESET)
			(WR && ADDR == OFS_IRQ_STAT && WDATA[IRQ_DONE] && !eng_done) |=> !s_r.stat;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	// The flag rises only on completion
	property p_flag_rise;
		@(posedge SYS_CLK) disable iff (RESET) (!s_r.stat && !eng_done) |=> !s_r.stat;
	endproperty
	a_flag_rise: assert property (p_flag_rise) else $error("flag set without completion");

	// A control write that switches off can never leave go set
	property p_go_off_refused;
		@(posedge SYS_CLK) disable iff (RESET) (WR && ADDR == OFS_CTRL0 && !WDATA[C0_ON]) |=> !s_r.ctrl0[C0_GO];
	endproperty
	a_go_off_refused: assert property (p_go_off_refused) else $error("go set while off");

	// Go rises only through an accepted start write
	property p_go_rise;
		@(posedge SYS_CLK) disable iff (RESET) (!s_r.ctrl0[C0_GO] && !wr_go) |=> !s_r.ctrl0[C0_GO];
	endproperty
	a_go_rise: assert property (p_go_rise) else $error("go rose without start");

	// Go is never seen with the module off
	property p_go_needs_on;
		@(posedge SYS_CLK) disable iff (RESET) s_r.ctrl0[C0_GO] |-> s_r.ctrl0[C0_ON];
	endproperty
	a_go_needs_on: assert property (p_go_needs_on) else $error("go while module off");

	// Bit-trial enable is a single-cycle pulse
	property p_tick_pulse;
		@(posedge SYS_CLK) disable iff (RESET) s_r.tick |=> !s_r.tick;
	endproperty
	a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

	// No bit trials are paced while idle
	property p_tick_idle;
		@(posedge SYS_CLK) disable iff (RESET) !s_r.ctrl0[C0_GO] |=> !s_r.tick;
	endproperty
	a_tick_idle: assert property (p_tick_idle) else $error("tick while idle");

	// Completion is reported as a single-cycle pulse
	property p_done_pulse;
		@(posedge SYS_CLK) disable iff (RESET) eng_done |=> !eng_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

	// Hold output is the engine's trial phase, one register later
	property p_hold_out;
		@(posedge SYS_CLK) disable iff (RESET) SAMPLE_HOLD == $past(eng_hold);
	endproperty
	a_hold_out: assert property (p_hold_out) else $error("hold output wrong");

	// Trial code output is the engine's code, one register later
	property p_trial_out;
		@(posedge SYS_CLK) disable iff (RESET) TRIAL_CODE == $past(eng_trial);
	endproperty
	a_trial_out: assert property (p_trial_out) else $error("trial output wrong");

	// Module-on output follows its bit
	property p_on_out;
		@(posedge SYS_CLK) disable iff (RESET) CONV_ON == s_r.ctrl0[C0_ON];
	endproperty
	a_on_out: assert property (p_on_out) else $error("module on output wrong");

	// Low result read shows the lower eight bits
	property p_res_lo;
		@(posedge SYS_CLK) disable iff (RESET)
			(RD && ADDR == OFS_RES_LO) |=> (RDATA == $past(s_r.res[7:0]));
	endproperty
	a_res_lo: assert property (p_res_lo) else $error("low result read wrong");

	// Polling control 0 shows the live go bit
	property p_go_read;
		@(posedge SYS_CLK) disable iff (RESET)
			(RD && ADDR == OFS_CTRL0) |=> (RDATA[C0_GO] == $past(s_r.ctrl0[C0_GO]));
	endproperty
	a_go_read: assert property (p_go_read) else $error("go read back wrong");

	// Status read shows the flag with zeros above
	property p_stat_read;
		@(posedge SYS_CLK) disable iff (RESET) (RD && ADDR == OFS_IRQ_STAT) |=> (RDATA == {7'h00, $past(s_r.stat)});
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read wrong");

	// Read data stand for one cycle only, zero otherwise
	property p_rdata_idle;
		@(posedge SYS_CLK) disable iff (RESET) !RD |=> (RDATA == 8'h00);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

	// Trials only run while go reads one
	property p_hold_in_conv;
		@(posedge SYS_CLK) disable iff (RESET) eng_hold |-> s_r.ctrl0[C0_GO];
	endproperty
	a_hold_in_conv: assert property (p_hold_in_conv) else $error("trial without go");

	// The mask alone gates wake; nothing global is consulted
	property p_wake_off;
		@(posedge SYS_CLK) disable iff (RESET) !s_r.mask |-> !WAKE;
	endproperty
	a_wake_off: assert property (p_wake_off) else $error("wake while masked");
endmodule

/* tb/sas_afe_model.sv */
// Analog front end model: channel levels, one sample-and-hold, comparator.
// Assumes trial codes are driven only while the hold is high.
`timescale 1ns/10ps
module sas_afe_model
	import sas_pkg::*;
(
	// Clock
	input  wire logic                       clk,
	// From the sequencer
	input  wire logic [CHAN_BITS-1:0]       chan_sel,
	input  wire logic                       vref_ext,
	input  wire logic                       sample_hold,
	input  wire logic [RES_BITS-1:0]        trial_code,
	// Levels per channel for each reference
	input  wire logic [15:0][RES_BITS-1:0]  lvl_int,
	input  wire logic [15:0][RES_BITS-1:0]  lvl_ext,
	// Comparator answer
	output logic                            comp_high
);
	logic [RES_BITS-1:0] held_r;
	logic [RES_BITS-1:0] live;
	logic                hold_q_r = 1'b0;
	logic                junk_r   = 1'b0;
	// Routed channel level, scaled by the chosen reference
	assign live = vref_ext ? lvl_ext[chan_sel] : lvl_int[chan_sel];
	// Capture as the hold closes; a toggling answer outside holds exposes early sampling
	always @(posedge clk) begin
		hold_q_r <= sample_hold;
		junk_r   <= ~junk_r;
		if (sample_hold && !hold_q_r) begin
			held_r <= live;
		end
	end
	// High while the held level is at or above the trial
	assign comp_high = sample_hold ? ((hold_q_r ? held_r : live) >= trial_code) : junk_r;
endmodule

/* tb/sar_adc_sequencer_tb_top.sv */
// Self-checking bench for the converter sequencer: random conversions and corner cases.
// Assumes the front end model answers trials from per-channel levels.
`timescale 1ns/10ps
module sar_adc_sequencer_tb_top
	import sas_pkg::*;
;
	logic                      sys_clk = 1'b0;
	logic                      reset   = 1'b1;
	logic [3:0]                addr    = 4'h0;
	logic [7:0]                wdata   = 8'h00;
	logic                      wr      = 1'b0;
	logic                      rd      = 1'b0;
	logic [7:0]                rdata;
	logic [7:0]                rv;
	logic [CHAN_BITS-1:0]      chan_sel;
	logic [RES_BITS-1:0]       trial_code;
	logic                      vref_ext, conv_on, sample_hold, comp_high, irq, wake;
	logic [15:0][RES_BITS-1:0] lvl_int, lvl_ext;
	int                        miscompares = 0;
	int                        samples_checked = 0;
	// System clock, 8 ns
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	sas_top u_dut (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .CHAN_SEL(chan_sel), .VREF_EXT(vref_ext), .CONV_ON(conv_on),
		.SAMPLE_HOLD(sample_hold), .TRIAL_CODE(trial_code), .COMP_HIGH(comp_high), .IRQ(irq), .WAKE(wake));
	sas_afe_model u_afe (.clk(sys_clk), .chan_sel(chan_sel), .vref_ext(vref_ext), .sample_hold(sample_hold),
		.trial_code(trial_code), .lvl_int(lvl_int), .lvl_ext(lvl_ext), .comp_high(comp_high));
	// One-cycle write; the trailing delay lets the design's updates land before checks
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr    <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Poll go until it reads zero; the bound lets a hang still reach the verdict
	task automatic wait_idle();
		int n = 0;
		rd_reg(OFS_CTRL0, rv);
		while (rv[C0_GO] !== 1'b0 && n < 3000) begin
			rd_reg(OFS_CTRL0, rv);
			n++;
		end
		chk(rv[C0_GO], 1'b0);
	endtask
	function automatic logic [RES_BITS-1:0] expect_code(input logic [3:0] ch, input logic v);
		return v ? lvl_ext[ch] : lvl_int[ch];
	endfunction
	task automatic summarize();
		$display("checked=%0d miscompares=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Watchdog: the slowest run is well under this many cycles
	initial begin
		repeat (60000) @(posedge sys_clk);
		miscompares++;
		summarize();
	end
	// Main sequence
	initial begin
		logic [3:0] ch;
		logic       vr;
		logic [9:0] ex;
		void'($urandom(22));
		for (int c = 0; c < 16; c++) begin
			lvl_int[c] = 10'($urandom);
			lvl_ext[c] = 10'($urandom);
		end
		lvl_int[0]  = 10'h000;
		lvl_int[15] = 10'h3ff;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		// Every register resets to zero, unmapped places read zero
		for (int a = 0; a < 16; a++) begin
			rd_reg(4'(a), rv);
			chk(rv, 8'h00);
		end
		wr_reg(OFS_CTRL0, 8'h02);
		rd_reg(OFS_CTRL0, rv);
		chk(rv, 8'h00);
		for (int i = 0; i < 8; i++) begin
			ch = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
			vr = 1'($urandom);
			ex = expect_code(ch, vr);
			wr_reg(OFS_CTRL1, {1'b0, 3'(i), 3'h0, vr});
			wr_reg(OFS_CTRL0, {2'h0, ch, 2'h1});
			wr_reg(OFS_IRQ_MASK, {7'h0, i[0]});
			chk(vref_ext, vr);
			chk(chan_sel, ch);
			chk(conv_on, 1'b1);
			repeat (4) @(posedge sys_clk);
			wr_reg(OFS_CTRL0, {2'h0, ch, 2'h3});
			rd_reg(OFS_CTRL0, rv);
			chk(rv[C0_GO], 1'b1);
			wr_reg(OFS_CTRL0, {2'h0, ch, 2'h1});
			rd_reg(OFS_CTRL0, rv);
			chk(rv[C0_GO], 1'b1);
			chk(irq, 1'b0);
			wait_idle();
			rd_reg(OFS_RES_HI, rv);
			chk(rv, {6'h0, ex[9:8]});
			rd_reg(OFS_RES_LO, rv);
			chk(rv, ex[7:0]);
			chk(trial_code, ex);
			chk(sample_hold, 1'b0);
			rd_reg(OFS_IRQ_STAT, rv);
			chk(rv, 8'h01);
			chk(irq, i[0]);
			chk(wake, i[0]);
			wr_reg(OFS_IRQ_MASK, 8'h01);
			rd_reg(OFS_IRQ_STAT, rv);
			chk(wake, 1'b1);
			wr_reg(OFS_IRQ_STAT, 8'h01);
			rd_reg(OFS_IRQ_STAT, rv);
			chk(rv, 8'h00);
			chk(irq, 1'b0);
			$display("test %0d done", i);
		end
		// Switching off mid-conversion abandons it; the next conversion must start clean
		wr_reg(OFS_CTRL1, 8'h70);
		wr_reg(OFS_CTRL0, 8'h3f);
		repeat (600) @(posedge sys_clk);
		wr_reg(OFS_CTRL0, 8'h00);
		rd_reg(OFS_CTRL0, rv);
		chk(rv, 8'h00);
		chk(sample_hold, 1'b0);
		rd_reg(OFS_IRQ_STAT, rv);
		chk(rv, 8'h00);
		wr_reg(OFS_CTRL1, 8'h00);
		wr_reg(OFS_CTRL0, 8'h01);
		repeat (4) @(posedge sys_clk);
		wr_reg(OFS_CTRL0, 8'h03);
		wait_idle();
		rd_reg(OFS_RES_HI, rv);
		chk(rv, {6'h0, lvl_int[0][9:8]});
		rd_reg(OFS_RES_LO, rv);
		chk(rv, lvl_int[0][7:0]);
		chk(trial_code, lvl_int[0]);
		$display("test abort done");
		summarize();
	end
endmodule
